// ### rlc_consts.svh
`ifndef RLC_CONSTS_SVH
`define RLC_CONSTS_SVH

// register offsets
`define RLC_OFS_GENERAL   8'h0A
`define RLC_OFS_GAIN01    8'h10
`define RLC_OFS_GAIN23    8'h11
`define RLC_OFS_SNOOPED   8'h12
`define RLC_OFS_SNOOP_CTL 8'h13
// general register fields
`define RLC_GEN_SWAP      5
`define RLC_GEN_EQSEL     4
`define RLC_GEN_FORCE     3
`define RLC_GEN_RSV       2
`define RLC_CTL_RESET     2'h1
`define RLC_CTL_SHUTDOWN  2'h0
`define RLC_CTL_ENABLE    2'h2
// snoop control fields
`define RLC_SNP_OFF       7
// sideband addresses and values
`define RLC_SB_PWR_ADDR   20'h0_0600
`define RLC_SB_LANE_ADDR  20'h0_0101
`define RLC_PWR_ACTIVE    2'h1
`endif

// ### rlc_host.sv
`timescale 1ns/1ns
module rlc_host (
    // pacing clock
    input  wire logic clk_in,
    // level of the pulled-up data wire
    input  wire logic sda_in,
    // lines driven by the host
    output logic      scl_out,
    output logic      sda_pull_out
);
    logic [6:0] dev_addr = 7'h44; // slave address put on the wire

    // idle bus: both lines released
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end

    // ten core cycles a phase, well over the slave's four-cycle minimum
    task automatic gap();
        repeat (10) @(negedge clk_in);
    endtask : gap

    // data moves only while the clock is low, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        scl_out = 1'b0;
        gap();
        sda_pull_out = ~b;
        gap();
        scl_out = 1'b1;
        gap();
        r = sda_in;
    endtask : bit_io

    // start is cond(0,1), stop is cond(1,0): data flips with clock high
    task automatic cond(input logic a, input logic b);
        scl_out = 1'b0;
        gap();
        sda_pull_out = a;
        gap();
        scl_out = 1'b1;
        gap();
        sda_pull_out = b;
        gap();
    endtask : cond

    // eight bits msb first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] d, input logic nak, output logic [7:0] r,
                           output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(nak, b);
        ack = ~b;
    endtask : byte_io

    // sub-address, then one data byte when nd is set
    task automatic wr(input logic [7:0] sub, input logic [7:0] d, input logic nd,
                      output logic ok);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        cond(1'b0, 1'b1);
        byte_io({dev_addr, 1'b0}, 1'b1, r, a0);
        byte_io(sub, 1'b1, r, ok);
        if (nd) begin
            byte_io(d, 1'b1, r, a1);
            ok = ok & a1;
        end
        cond(1'b1, 1'b0);
        ok = ok & a0;
    endtask : wr

    // n bytes, acked except the last, which is refused to end the read
    task automatic rd(input int n, output logic [15:0] v, output logic ok);
        logic [7:0] r;
        logic       a;
        v = 16'h0000;
        cond(1'b0, 1'b1);
        byte_io({dev_addr, 1'b1}, 1'b1, r, ok);
        for (int i = 1; i <= n; i++) begin
            byte_io(8'hFF, i == n, r, a);
            v = {v[7:0], r};
        end
        cond(1'b1, 1'b0);
    endtask : rd
endmodule : rlc_host

// ### rlc_pkg.sv
package rlc_pkg;
    // serial slave phases
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_SUB, ST_ACK_SUB,
        ST_WDATA, ST_ACK_DATA, ST_RDATA, ST_RD_ACK
    } rlc_i2c_t;

    // one sideband write seen by the snoop decoder
    typedef struct packed {
        logic        wr;
        logic [19:0] addr;
        logic [7:0]  data;
    } rlc_snoop_t;

    // link-domain capture state
    typedef struct packed {
        logic       tog_pwr;
        logic       tog_lane;
        logic [1:0] pwr_hold;
        logic [4:0] lane_hold;
    } rlc_link_t;

    // core-domain state
    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [1:0] hpd0_sync;
        logic [1:0] hpd1_sync;
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic [2:0] tp_sync;
        logic [2:0] tl_sync;
        rlc_i2c_t   st;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic       rw;
        logic       acked;
        logic       sda_oe;
        logic       swap;
        logic       eq_sel;
        logic       hp_force;
        logic       gen_rsv;
        logic [1:0] ctl;
        logic [7:0] gain01;
        logic [7:0] gain23;
        logic [1:0] pwr;
        logic [4:0] lane;
        logic       snoop_off;
        logic [1:0] snp_rsv;
        logic [3:0] lane_off;
        logic       hot_plug;
        logic [3:0] lane_en;
        logic       shutdown;
        logic       link_en;
    } rlc_state_t;
endpackage : rlc_pkg

// ### rlc_regs.sv
`timescale 1ns/1ns
`include "rlc_consts.svh"
module rlc_regs
    import rlc_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h44
) (
    // core clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // serial register port (open drain data)
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    // pins
    input  wire logic        hot_plug_input_in,
    input  wire logic        hot_plug_input_alt_in,
    input  wire logic [1:0]  gain_strap_pins_in,
    // snoop decoder side, on link clock
    input  wire logic        snoop_clk_in,
    input  wire rlc_snoop_t  snoop_in,
    // lane control
    output logic             hot_plug_out,
    output logic [3:0]       lane_enable_out,
    output logic [15:0]      lane_gain_out,
    output logic             link_shutdown_out,
    output logic             link_enable_out
);
    rlc_state_t q;          // core state
    rlc_state_t d;          // its next value
    rlc_link_t  lq;         // link state
    rlc_link_t  ld;         // its next value
    logic       scl_rise;   // qualified clock edges
    logic       scl_fall;
    logic       start;      // bus conditions
    logic       stop;
    logic       ev_pwr;     // crossed capture events
    logic       ev_lane;
    logic       clr;        // select bit1 fell
    logic [7:0] rdv;        // read data for next byte
    logic [3:0] sg;         // strap-derived gain

    // register read map; unmapped offsets read zero
    function automatic logic [7:0] rd_reg(input rlc_state_t s, input logic [7:0] a);
        case (a)
            `RLC_OFS_GENERAL:   rd_reg = {2'h0, s.swap, s.eq_sel, s.hp_force, s.gen_rsv, s.ctl};
            `RLC_OFS_GAIN01:    rd_reg = s.gain01;
            `RLC_OFS_GAIN23:    rd_reg = s.gain23;
            `RLC_OFS_SNOOPED:   rd_reg = {1'b0, s.pwr, s.lane};
            `RLC_OFS_SNOOP_CTL: rd_reg = {s.snoop_off, 1'b0, s.snp_rsv, s.lane_off};
            default:            rd_reg = 8'h00;
        endcase
    endfunction : rd_reg

    // link domain: capture snooped writes, flag each with a toggle
    // limitation: a second write of the same field within about
    // three core cycles may be merged into one
    always_comb begin
        ld = lq;
        if (snoop_in.wr && snoop_in.addr == `RLC_SB_PWR_ADDR) begin
            ld.pwr_hold = snoop_in.data[1:0];
            ld.tog_pwr  = ~lq.tog_pwr;
        end
        if (snoop_in.wr && snoop_in.addr == `RLC_SB_LANE_ADDR) begin
            ld.lane_hold = snoop_in.data[4:0];
            ld.tog_lane  = ~lq.tog_lane;
        end
    end

    // link-domain register
    always_ff @(posedge snoop_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    // core next-state logic
    always_comb begin
        d        = q;
        clr      = 1'b0;
        rdv      = rd_reg(q, q.ptr);
        sg       = {q.strap_s2, 2'h0};
        // synchronisers; stage 0 feeds only stage 1
        d.scl_sync  = {q.scl_sync[1:0], scl_in};
        d.sda_sync  = {q.sda_sync[1:0], sda_in};
        d.hpd0_sync = {q.hpd0_sync[0], hot_plug_input_in};
        d.hpd1_sync = {q.hpd1_sync[0], hot_plug_input_alt_in};
        d.strap_s1  = gain_strap_pins_in;
        d.strap_s2  = q.strap_s1;
        d.tp_sync   = {q.tp_sync[1:0], lq.tog_pwr};
        d.tl_sync   = {q.tl_sync[1:0], lq.tog_lane};
        scl_rise = q.scl_sync[1] & ~q.scl_sync[2];
        scl_fall = ~q.scl_sync[1] & q.scl_sync[2];
        start    = q.scl_sync[1] & q.scl_sync[2] & ~q.sda_sync[1] & q.sda_sync[2];
        stop     = q.scl_sync[1] & q.scl_sync[2] & q.sda_sync[1] & ~q.sda_sync[2];
        ev_pwr   = q.tp_sync[2] ^ q.tp_sync[1];
        ev_lane  = q.tl_sync[2] ^ q.tl_sync[1];

        // serial slave: sample on rise, drive on fall
        if (start) begin
            d.st     = ST_ADDR;
            d.cnt    = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.st     = ST_IDLE;
            d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (q.st)
                ST_ADDR, ST_SUB, ST_WDATA: begin
                    d.shift = {q.shift[6:0], q.sda_sync[1]};
                    d.cnt   = q.cnt + 4'h1;
                end
                ST_RD_ACK: d.acked = ~q.sda_sync[1];
                default: ;
            endcase
        end else if (scl_fall) begin
            case (q.st)
                ST_ADDR: begin
                    if (q.cnt == 4'h8) begin
                        // foreign address: stay silent till next start
                        if (q.shift[7:1] == SLAVE_ADDR) begin
                            d.sda_oe = 1'b1;
                            d.rw     = q.shift[0];
                            d.st     = ST_ACK_ADDR;
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR, ST_RD_ACK: begin
                    if (q.st == ST_RD_ACK && !q.acked) begin
                        d.sda_oe = 1'b0; // master nack ends read
                        d.st     = ST_IDLE;
                    end else if (q.rw) begin
                        // read begins at the held pointer
                        d.shift  = rdv;
                        d.sda_oe = ~rdv[7];
                        d.cnt    = 4'h1;
                        d.st     = ST_RDATA;
                    end else begin
                        d.sda_oe = 1'b0;
                        d.cnt    = 4'h0;
                        d.st     = ST_SUB;
                    end
                end
                ST_SUB: begin
                    if (q.cnt == 4'h8) begin
                        d.ptr    = q.shift;
                        d.sda_oe = 1'b1;
                        d.st     = ST_ACK_SUB;
                    end
                end
                ST_ACK_SUB, ST_ACK_DATA: begin
                    d.sda_oe = 1'b0;
                    d.cnt    = 4'h0;
                    d.st     = ST_WDATA;
                end
                ST_WDATA: begin
                    if (q.cnt == 4'h8) begin
                        d.ptr    = q.ptr + 8'h01;
                        d.sda_oe = 1'b1;
                        d.st     = ST_ACK_DATA;
                        case (q.ptr)
                            `RLC_OFS_GENERAL: begin
                                d.swap     = q.shift[`RLC_GEN_SWAP];
                                d.eq_sel   = q.shift[`RLC_GEN_EQSEL];
                                d.hp_force = q.shift[`RLC_GEN_FORCE];
                                d.gen_rsv  = q.shift[`RLC_GEN_RSV];
                                d.ctl      = q.shift[1:0];
                                clr        = q.ctl[1] & ~q.shift[1];
                            end
                            // gain writes count only when register-selected
                            `RLC_OFS_GAIN01: if (q.eq_sel) d.gain01 = q.shift;
                            `RLC_OFS_GAIN23: if (q.eq_sel) d.gain23 = q.shift;
                            `RLC_OFS_SNOOP_CTL: begin
                                d.snoop_off = q.shift[`RLC_SNP_OFF];
                                d.snp_rsv   = q.shift[5:4];
                                d.lane_off  = q.shift[3:0];
                            end
                            default: ; // read-only or unmapped
                        endcase
                    end
                end
                ST_RDATA: begin
                    if (q.cnt == 4'h8) begin
                        d.sda_oe = 1'b0; // release for master ack
                        d.ptr    = q.ptr + 8'h01;
                        d.st     = ST_RD_ACK;
                    end else begin
                        d.shift  = {q.shift[6:0], 1'b0};
                        d.sda_oe = ~q.shift[6];
                        d.cnt    = q.cnt + 4'h1;
                    end
                end
                default: ;
            endcase
        end

        // clear first so a same-cycle capture wins
        if (clr) begin
            d.pwr  = 2'h0;
            d.lane = 5'h00;
        end
        if (ev_pwr) begin
            d.pwr = lq.pwr_hold;
        end
        if (ev_lane) begin
            d.lane = lq.lane_hold;
        end

        // strap mode: hardware keeps the gain fields current
        if (!q.eq_sel) begin
            d.gain01 = {sg, sg};
            d.gain23 = {sg, sg};
        end

        // hot-plug source
        d.hot_plug = q.hp_force | (q.swap ? q.hpd1_sync[1] : q.hpd0_sync[1]);

        // function mode outputs
        d.shutdown = (q.ctl == `RLC_CTL_SHUTDOWN);
        d.link_en  = (q.ctl == `RLC_CTL_ENABLE);

        // per-lane enable
        for (int i = 0; i < 4; i++) begin
            if (q.ctl != `RLC_CTL_ENABLE) begin
                d.lane_en[i] = 1'b0;
            end else if (!q.snoop_off) begin
                // lane-off bits are ignored here
                d.lane_en[i] = (q.pwr == `RLC_PWR_ACTIVE) && (q.lane > 5'(i));
            end else begin
                d.lane_en[i] = ~q.lane_off[i];
            end
        end
    end

    // core register; select field resets to idle-not-shutdown, and the
    // serial syncs to the idle-high line level so no false edge follows
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q          <= '0;
            q.ctl      <= `RLC_CTL_RESET;
            q.scl_sync <= 3'h7;
            q.sda_sync <= 3'h7;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops; data line only ever pulls low
    assign sda_out           = q.gen_rsv & 1'b0;
    assign sda_oe_out        = q.sda_oe;
    assign hot_plug_out      = q.hot_plug;
    assign lane_enable_out   = q.lane_en;
    assign lane_gain_out     = {q.gain23, q.gain01};
    assign link_shutdown_out = q.shutdown;
    assign link_enable_out   = q.link_en;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_lanes_mode_off: assert property ((q.ctl != `RLC_CTL_ENABLE) |=> (q.lane_en == 4'h0))
        else $error("lane enabled outside enable mode");
    a_shutdown_flag: assert property ((q.ctl == `RLC_CTL_SHUTDOWN) |=> q.shutdown)
        else $error("shutdown not flagged");
    a_hpd_force: assert property (q.hp_force |=> q.hot_plug)
        else $error("forced hot-plug not high");
    a_hpd_swap_pin: assert property (
        (!q.hp_force && q.swap) |=> (q.hot_plug == $past(q.hpd1_sync[1])))
        else $error("swapped hot-plug pin not followed");
    a_strap_gain: assert property (
        !q.eq_sel |=> (q.gain01 == {2{$past(q.strap_s2), 2'h0}}
            && q.gain23 == {2{$past(q.strap_s2), 2'h0}}))
        else $error("gain not following straps");
    a_snoop_count: assert property (
        (q.ctl == `RLC_CTL_ENABLE && !q.snoop_off && q.pwr == `RLC_PWR_ACTIVE
            && q.lane == 5'h02) |=> (q.lane_en == 4'h3))
        else $error("lane count not applied");
    a_snoop_power: assert property (
        (q.ctl == `RLC_CTL_ENABLE && !q.snoop_off && q.pwr != `RLC_PWR_ACTIVE)
            |=> (q.lane_en == 4'h0))
        else $error("lanes on in low power state");
    a_lane_off_bits: assert property (
        (q.ctl == `RLC_CTL_ENABLE && q.snoop_off) |=> (q.lane_en == ~$past(q.lane_off)))
        else $error("lane-off bits not applied");
    a_fall_clears: assert property (
        ($fell(q.ctl[1]) && !$past(ev_pwr) && !$past(ev_lane))
            |-> (q.pwr == 2'h0 && q.lane == 5'h00))
        else $error("snooped fields not cleared");
    a_pwr_capture: assert property (ev_pwr |=> (q.pwr == $past(lq.pwr_hold)))
        else $error("power state not captured");
    a_lane_capture: assert property (ev_lane |=> (q.lane == $past(lq.lane_hold)))
        else $error("lane count not captured");
    a_sub_pointer: assert property (
        (q.st == ST_SUB && q.cnt == 4'h8 && scl_fall && !start && !stop)
            |=> (q.ptr == $past(q.shift) && q.st == ST_ACK_SUB))
        else $error("sub-address not loaded");
    // register-selected gains move only on a completed host data byte
    a_gain_held: assert property (
        (q.eq_sel && !(scl_fall && q.st == ST_WDATA && q.cnt == 4'h8))
            |=> ($stable(q.gain01) && $stable(q.gain23)))
        else $error("gain changed without host write");
    a_link_enable_flag: assert property ((q.ctl == `RLC_CTL_ENABLE) |=> q.link_en)
        else $error("link enable not flagged");
    a_snoop_ignores_off: assert property (
        (q.ctl == `RLC_CTL_ENABLE && !q.snoop_off && q.pwr == `RLC_PWR_ACTIVE
            && q.lane == 5'h04 && q.lane_off != 4'h0) |=> (q.lane_en == 4'hF))
        else $error("lane-off bits acted while snooping");
    a_zero_lanes: assert property (
        (q.ctl == `RLC_CTL_ENABLE && !q.snoop_off && q.lane == 5'h00) |=> (q.lane_en == 4'h0))
        else $error("lanes on with zero lane count");
    a_read_pointer: assert property (
        (q.st == ST_RDATA && q.cnt == 4'h8 && scl_fall && !start && !stop)
            |=> (q.ptr == $past(q.ptr) + 8'h01))
        else $error("read pointer not advanced");
endmodule : rlc_regs

// ### tb.sv
`timescale 1ns/1ns
`include "rlc_consts.svh"
module tb import rlc_pkg::*;;
    localparam logic [7:0] OFS [5] = '{`RLC_OFS_GENERAL, `RLC_OFS_GAIN01,
        `RLC_OFS_GAIN23, `RLC_OFS_SNOOPED, `RLC_OFS_SNOOP_CTL};
    logic        clk_in;     // core clock
    logic        snoop_clk;  // link clock, phase unrelated to core
    logic        reset_n_in;
    logic        scl;
    logic        pull;       // host pulling data low
    logic        sda_drv;
    logic        sda_oe;
    wire         sda = ~(pull | (sda_oe & ~sda_drv)); // pulled-up wire
    logic        hp_def;
    logic        hp_alt;
    logic [1:0]  strap;
    rlc_snoop_t  snoop;
    logic        hot_plug;
    logic [3:0]  lane_en;
    logic [15:0] gain;
    logic        shut;
    logic        link_en;
    logic [15:0] v;          // last read data
    logic        ok;         // all acks seen
    int          n_errors = 0;
    int          n_compared = 0;

    rlc_regs u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_drv), .sda_oe_out(sda_oe), .hot_plug_input_in(hp_def),
        .hot_plug_input_alt_in(hp_alt), .gain_strap_pins_in(strap),
        .snoop_clk_in(snoop_clk), .snoop_in(snoop), .hot_plug_out(hot_plug),
        .lane_enable_out(lane_en), .lane_gain_out(gain), .link_shutdown_out(shut),
        .link_enable_out(link_en));
    rlc_host u_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] sub, input logic [7:0] d);
        u_host.wr(sub, d, 1'b1, ok);
        chk(ok, 16'h0001);
    endtask : wr

    // set the pointer, then read n bytes from it
    task automatic rd(input logic [7:0] sub, input int n, input logic [15:0] exp);
        u_host.wr(sub, 8'h00, 1'b0, ok);
        chk(ok, 16'h0001);
        u_host.rd(n, v, ok);
        chk(ok, 16'h0001);
        chk(v, exp);
    endtask : rd

    // one sideband write; lines show inverted junk once released
    task automatic snp(input logic [19:0] a, input logic [7:0] d);
        @(negedge snoop_clk);
        snoop = {1'b1, a, d};
        @(negedge snoop_clk);
        snoop = {1'b0, ~a, ~d};
        repeat (12) @(negedge clk_in);
    endtask : snp

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        snoop_clk = 1'b0;
        #7;
        forever #24 snoop_clk = ~snoop_clk;
    end
    // tests need about 34k cycles; a hang is cut well after that
    initial begin
        repeat (90000) @(posedge clk_in);
        n_errors++;
        give_verdict();
    end

    initial begin
        reset_n_in = 1'b0;
        hp_def = 1'b0;
        hp_alt = 1'b0;
        strap = 2'b00;
        snoop = '0;
        repeat (8) @(negedge clk_in);
        reset_n_in = 1'b1;
        repeat (5) @(negedge clk_in);
        chk({10'h000, shut, link_en, lane_en}, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            rd(OFS[i], 1, {15'h0000, i == 0});
        end
        $display("test reset values done");
        wr(`RLC_OFS_SNOOP_CTL, 8'h80);
        for (int c = 0; c < 4; c++) begin
            wr(`RLC_OFS_GENERAL, 8'(c));
            chk({shut, link_en, lane_en}, {c == 0, c == 2, (c == 2) ? 4'hF : 4'h0});
        end
        $display("test function codes done");
        for (int s = 0; s < 2; s++) begin
            for (int f = 0; f < 2; f++) begin
                wr(`RLC_OFS_GENERAL, {2'b00, s[0], 1'b0, f[0], 3'b010});
                for (int p = 0; p < 2; p++) begin
                    hp_def = p[0];
                    hp_alt = ~p[0];
                    repeat (8) @(negedge clk_in);
                    chk(hot_plug, f[0] | (s[0] ^ p[0]));
                end
            end
        end
        $display("test hot plug done");
        strap = 2'b10;
        repeat (8) @(negedge clk_in);
        chk(gain, 16'h8888);
        wr(`RLC_OFS_GAIN01, 8'h5A);
        rd(`RLC_OFS_GAIN01, 1, 16'h0088);
        wr(`RLC_OFS_GENERAL, 8'h12);
        wr(`RLC_OFS_GAIN01, 8'h5A);
        wr(`RLC_OFS_GAIN23, 8'hE3);
        strap = 2'b01;
        repeat (8) @(negedge clk_in);
        chk(gain, 16'hE35A);
        rd(`RLC_OFS_GAIN01, 2, 16'h5AE3);
        $display("test gain select done");
        wr(`RLC_OFS_SNOOP_CTL, 8'h00);
        snp(`RLC_SB_PWR_ADDR, 8'h01);
        for (int k = 1; k < 5; k++) begin
            snp(`RLC_SB_LANE_ADDR, 8'(k));
            chk(lane_en, 16'((1 << k) - 1));
        end
        rd(`RLC_OFS_SNOOPED, 1, 16'h0024);
        snp(`RLC_SB_PWR_ADDR, 8'h02);
        chk(lane_en, 16'h0000);
        rd(`RLC_OFS_SNOOPED, 1, 16'h0044);
        snp(`RLC_SB_PWR_ADDR, 8'h01);
        snp(20'h0_0602, 8'h02);
        chk(lane_en, 16'h000F);
        wr(`RLC_OFS_SNOOP_CTL, 8'h0F);
        chk(lane_en, 16'h000F);
        wr(`RLC_OFS_SNOOP_CTL, 8'h85);
        chk(lane_en, 16'h000A);
        snp(`RLC_SB_LANE_ADDR, 8'h01);
        chk(lane_en, 16'h000A);
        $display("test snoop lanes done");
        wr(`RLC_OFS_GENERAL, 8'h11);
        rd(`RLC_OFS_SNOOPED, 1, 16'h0000);
        chk(lane_en, 16'h0000);
        wr(`RLC_OFS_SNOOPED, 8'h7F);
        rd(`RLC_OFS_SNOOPED, 1, 16'h0000);
        rd(8'h20, 1, 16'h0000);
        u_host.dev_addr = 7'h45;
        u_host.wr(`RLC_OFS_GAIN01, 8'h00, 1'b1, ok);
        chk(ok, 16'h0000);
        u_host.dev_addr = 7'h44;
        rd(`RLC_OFS_GAIN01, 1, 16'h005A);
        u_host.rd(1, v, ok);
        chk(v, 16'h00E3);
        $display("test refusals done");
        give_verdict();
    end
endmodule : tb
